// File: design/pfm_pin_mux.sv
`timescale 1ns/1ps
`include "pfm_regs.svh"
// Overview of operation
// - mode-select pin sampled after release of por or forced reset
// - after reset pin becomes debug link
// - debug enable turns on pin pull-up
// - debug enable set by reset, software clears
// - pin high runs, held low enters background
// - each debug bit lasts 16 debug clocks
// - pseudo open-drain with brief driven high pulses
// - seventeen bidirectional pins plus one output-only
// - outputs get drive strength and slew choice
// - inputs get selectable internal pull-up
// - reset leaves pins high-z inputs, no pull-up except on port a bit4
// - port read follows direction bit always
// - ganged output beats every digital peripheral
// - ganged pins copy port c bit0 settings
// - iic select moves clock and data pins
// - timer1 select moves both channel pins
// - comparator and converter share pin together
// - port a bit5 output is open-drain
// - reset enable sticks until power-on reset
// - non-por reset drives reset pin low 66 cycles
module pfm_pin_mux (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        por_n,
  input  wire logic        reset_was_por,
  input  wire logic        reset_was_forced,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [17:0] pin_in,
  output logic      [17:0] pin_out,
  output logic      [17:0] pin_oe_n,
  output logic      [17:0] pin_pullup,
  output logic      [17:0] pin_drive_hi,
  output logic      [17:0] pin_slew,
  input  wire logic [17:0] periph_en,
  input  wire logic [17:0] periph_out,
  input  wire logic [17:0] periph_oe,
  output logic      [17:0] periph_in,
  input  wire logic        iic_en,
  input  wire logic        iic_scl_out,
  input  wire logic        iic_scl_oe,
  input  wire logic        iic_sda_out,
  input  wire logic        iic_sda_oe,
  output logic             iic_scl_in,
  output logic             iic_sda_in,
  input  wire logic [1:0]  timer1_en,
  input  wire logic [1:0]  timer1_out,
  input  wire logic [1:0]  timer1_oe,
  output logic      [1:0]  timer1_in,
  input  wire logic        comparator_output_en,
  input  wire logic        comparator_output,
  input  wire logic        comparator_en,
  input  wire logic [1:0]  adc_en,
  output logic             comparator_connect,
  output logic      [1:0]  adc_connect,
  input  wire logic        dbg_clk_en,
  input  wire logic        dbg_drive_low,
  output logic             dbg_rx,
  output logic             dbg_bit_sample,
  output logic             dbg_bit_done,
  output logic             dbg_bit_busy,
  output logic             dbg_link_active,
  output logic             active_background,
  output logic             ext_reset_req
);
  import pfm_pkg::*;

  logic [17:0]     data_reg;
  logic [17:0]     dir_reg;
  logic [17:0]     pull_reg;
  logic [17:0]     drive_reg;
  logic [17:0]     slew_reg;
  logic [17:0]     gang_reg;
  logic            debug_pin_enable;
  logic            reset_pin_enable;
  logic            iic_pin_select;
  logic            timer1_pin_select;
  logic [17:0]     pin_sync;
  logic            ack_reg;
  logic            wr_fire;
  logic            rd_fire;
  logic [31:0]     wmask;
  logic [17:0]     rd_port;
  logic [31:0]     rdata_next;
  pfm_mode_t       mode_reg;
  logic            mode_done_reg;
  logic [1:0]      settle_reg;
  pfm_rpin_state_t rp_state_reg;
  logic [6:0]      rp_cnt_reg;
  logic            rp_drive;
  logic            dbg_low_d_reg;
  logic [1:0]      speedup_reg;
  logic [17:0]     scl_at;
  logic [17:0]     sda_at;
  logic [17:0]     t0_at;
  logic [17:0]     t1_at;
  logic [17:0]     oe_next;
  logic [17:0]     val_next;
  logic [17:0]     str_next;
  logic [17:0]     slw_next;
  logic [17:0]     pul_next;

  pfm_sync #(.WIDTH(18)) u_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  pfm_bit_timer u_bit (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .dbg_clk_en (dbg_clk_en),
    .link_en    (dbg_link_active),
    .line_in    (pin_sync[`PFM_PA4]),
    .bit_sample (dbg_bit_sample),
    .bit_done   (dbg_bit_done),
    .bit_busy   (dbg_bit_busy)
  );

  // ---------------- avalon slave, one wait state per access
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign wr_fire         = avs_write & ack_reg;
  assign rd_fire         = avs_read & ack_reg;
  assign wmask           = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                            {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end
  end

  function automatic logic [17:0] merge(input logic [17:0] old_v, input logic [31:0] wd,
                                        input logic [31:0] m);
    merge = (old_v & ~m[17:0]) | (wd[17:0] & m[17:0]);
  endfunction

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      data_reg  <= `PFM_PIN_RST;
      dir_reg   <= `PFM_PIN_RST;
      pull_reg  <= `PFM_PIN_RST;
      drive_reg <= `PFM_PIN_RST;
      slew_reg  <= `PFM_PIN_RST;
      gang_reg  <= `PFM_PIN_RST;
    end else if (wr_fire) begin
      case (avs_address)
        `PFM_OFS_DATA:  data_reg  <= merge(data_reg, avs_writedata, wmask);
        `PFM_OFS_DIR:   dir_reg   <= merge(dir_reg, avs_writedata, wmask);
        `PFM_OFS_PULL:  pull_reg  <= merge(pull_reg, avs_writedata, wmask);
        `PFM_OFS_DRIVE: drive_reg <= merge(drive_reg, avs_writedata, wmask);
        `PFM_OFS_SLEW:  slew_reg  <= merge(slew_reg, avs_writedata, wmask);
        `PFM_OFS_GANG:  gang_reg  <= merge(gang_reg, avs_writedata, wmask) & `PFM_GANG_MASK;
        default: ;
      endcase
    end
  end

  // debug enable returns after every reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      debug_pin_enable  <= `PFM_OPT1_RSTV;
      iic_pin_select    <= 1'(`PFM_OPT2_RSTV);
      timer1_pin_select <= 1'b0;
    end else if (wr_fire && avs_byteenable[0]) begin
      if (avs_address == `PFM_OFS_OPT1) begin
        debug_pin_enable <= avs_writedata[`PFM_OPT1_DBG];
      end
      if (avs_address == `PFM_OFS_OPT2) begin
        iic_pin_select    <= avs_writedata[`PFM_OPT2_IIC];
        timer1_pin_select <= avs_writedata[`PFM_OPT2_TMR];
      end
    end
  end

  // reset pin role survives every reset but power-on
  always_ff @(posedge mclk or negedge por_n) begin
    if (!por_n) begin
      reset_pin_enable <= 1'b0;
    end else if (wr_fire && avs_byteenable[0] && avs_address == `PFM_OFS_OPT1 &&
                 avs_writedata[`PFM_OPT1_RST]) begin
      reset_pin_enable <= 1'b1;
    end
  end

  // port read: output pins give latch, inputs give pin
  assign rd_port = (dir_reg & data_reg) | (~dir_reg & pin_sync);

  always_comb begin
    rdata_next = 32'h00000000;
    case (avs_address)
      `PFM_OFS_DATA:  rdata_next[17:0] = rd_port;
      `PFM_OFS_DIR:   rdata_next[17:0] = dir_reg;
      `PFM_OFS_PULL:  rdata_next[17:0] = pull_reg;
      `PFM_OFS_DRIVE: rdata_next[17:0] = drive_reg;
      `PFM_OFS_SLEW:  rdata_next[17:0] = slew_reg;
      `PFM_OFS_GANG:  rdata_next[17:0] = gang_reg;
      `PFM_OFS_OPT1: begin
        rdata_next[`PFM_OPT1_DBG] = debug_pin_enable;
        rdata_next[`PFM_OPT1_RST] = reset_pin_enable;
      end
      `PFM_OFS_OPT2: begin
        rdata_next[`PFM_OPT2_IIC] = iic_pin_select;
        rdata_next[`PFM_OPT2_TMR] = timer1_pin_select;
      end
      `PFM_OFS_STAT: begin
        rdata_next[`PFM_STAT_BG]   = (mode_reg == MODE_BACKGROUND);
        rdata_next[`PFM_STAT_RPIN] = rp_drive;
      end
      default: rdata_next = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read & ~ack_reg) begin
      avs_readdata <= rdata_next;
    end
  end

  // ---------------- mode select after reset release
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      settle_reg    <= 2'h0;
      mode_done_reg <= 1'b0;
      mode_reg      <= MODE_RUN;
    end else if (!mode_done_reg) begin
      settle_reg <= settle_reg + 2'h1;
      if (settle_reg == `PFM_MODE_SETTLE) begin
        mode_done_reg <= 1'b1;
        if ((reset_was_por | reset_was_forced) && !pin_sync[`PFM_PA4]) begin
          mode_reg <= MODE_BACKGROUND;
        end else begin
          mode_reg <= MODE_RUN;
        end
      end
    end
  end

  // pin is only a mode input until the sample is taken
  assign dbg_link_active   = mode_done_reg & debug_pin_enable;
  assign active_background = (mode_reg == MODE_BACKGROUND);
  assign dbg_rx            = pin_sync[`PFM_PA4];

  // speedup pulse when the controller releases a driven low
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dbg_low_d_reg <= 1'b0;
      speedup_reg   <= 2'h0;
    end else begin
      dbg_low_d_reg <= dbg_drive_low & dbg_link_active;
      if (dbg_low_d_reg && !(dbg_drive_low & dbg_link_active)) begin
        speedup_reg <= `PFM_SPEEDUP_CYC;
      end else if (speedup_reg != 2'h0) begin
        speedup_reg <= speedup_reg - 2'h1;
      end
    end
  end

  // ---------------- reset pin pulse after non-por reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rp_state_reg <= RP_IDLE;
      rp_cnt_reg   <= 7'h00;
    end else begin
      case (rp_state_reg)
        RP_IDLE: begin
          rp_cnt_reg <= 7'h00;
          if (reset_pin_enable && !reset_was_por) begin
            rp_state_reg <= RP_DRIVE;
          end else begin
            rp_state_reg <= RP_DONE;
          end
        end
        RP_DRIVE: begin
          rp_cnt_reg <= rp_cnt_reg + 7'h01;
          if (rp_cnt_reg == `PFM_RST_PULSE - 7'h01) begin
            rp_state_reg <= RP_DONE;
          end
        end
        RP_DONE: rp_state_reg <= RP_DONE;
        default: rp_state_reg <= RP_IDLE;
      endcase
    end
  end

  assign rp_drive      = (rp_state_reg == RP_DRIVE);
  assign ext_reset_req = reset_pin_enable & ~rp_drive & ~pin_sync[`PFM_PA5];

  // ---------------- relocation of iic and timer1 pins
  assign scl_at = iic_pin_select ? (18'h00001 << `PFM_PB7)
                                 : (18'h00001 << `PFM_PA3);
  assign sda_at = iic_pin_select ? (18'h00001 << `PFM_PB6)
                                 : (18'h00001 << `PFM_PA2);
  assign t0_at  = timer1_pin_select ? (18'h00001 << `PFM_PC0)
                                    : (18'h00001 << `PFM_PA0);
  assign t1_at  = timer1_pin_select ? (18'h00001 << `PFM_PC1)
                                    : (18'h00001 << `PFM_PB5);

  assign iic_scl_in   = |(pin_sync & scl_at);
  assign iic_sda_in   = |(pin_sync & sda_at);
  assign timer1_in[0] = |(pin_sync & t0_at);
  assign timer1_in[1] = |(pin_sync & t1_at);
  assign periph_in    = pin_sync;

  // analog users are not exclusive
  assign comparator_connect = comparator_en;
  assign adc_connect        = adc_en;

  // ---------------- per pin owner, lowest to highest priority
  genvar g;
  generate
    for (g = 0; g < `PFM_NPIN; g++) begin : g_pin
      always_comb begin
        oe_next[g]  = dir_reg[g];
        val_next[g] = data_reg[g];
        str_next[g] = drive_reg[g];
        slw_next[g] = slew_reg[g];
        if (periph_en[g]) begin
          oe_next[g]  = periph_oe[g];
          val_next[g] = periph_out[g];
        end
        if (iic_en && scl_at[g]) begin
          oe_next[g]  = iic_scl_oe;
          val_next[g] = iic_scl_out;
        end
        if (iic_en && sda_at[g]) begin
          oe_next[g]  = iic_sda_oe;
          val_next[g] = iic_sda_out;
        end
        if (timer1_en[0] && t0_at[g]) begin
          oe_next[g]  = timer1_oe[0];
          val_next[g] = timer1_out[0];
        end
        if (timer1_en[1] && t1_at[g]) begin
          oe_next[g]  = timer1_oe[1];
          val_next[g] = timer1_out[1];
        end
        if (gang_reg[g]) begin
          oe_next[g]  = 1'b1;
          val_next[g] = data_reg[`PFM_PC0];
          str_next[g] = drive_reg[`PFM_PC0];
          slw_next[g] = slew_reg[`PFM_PC0];
        end
        pul_next[g] = pull_reg[g] & ~oe_next[g];
        if (g == `PFM_PA4) begin
          // output-only pin: port, comparator out or debug link
          pul_next[g] = 1'b0;
          if (comparator_output_en) begin
            oe_next[g]  = 1'b1;
            val_next[g] = comparator_output;
          end
          if (dbg_link_active || !mode_done_reg) begin
            oe_next[g]  = (dbg_drive_low & dbg_link_active) | (speedup_reg != 2'h0);
            val_next[g] = ~(dbg_drive_low & dbg_link_active);
            pul_next[g] = 1'b1;
          end
        end
        if (g == `PFM_PA5) begin
          if (reset_pin_enable) begin
            oe_next[g]  = rp_drive;
            val_next[g] = 1'b0;
            pul_next[g] = 1'b1;
          end else begin
            oe_next[g] = oe_next[g] & ~val_next[g];
          end
        end
      end

      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          pin_out[g]      <= 1'b0;
          pin_oe_n[g]     <= 1'b1;
          pin_pullup[g]   <= (g == `PFM_PA4);
          pin_drive_hi[g] <= 1'b0;
          pin_slew[g]     <= 1'b0;
        end else begin
          pin_out[g]      <= val_next[g];
          pin_oe_n[g]     <= ~oe_next[g];
          pin_pullup[g]   <= pul_next[g];
          pin_drive_hi[g] <= str_next[g] & oe_next[g];
          pin_slew[g]     <= slw_next[g] & oe_next[g];
        end
      end
    end
  endgenerate

endmodule

// File: design/pfm_regs.svh
`ifndef PFM_REGS_SVH
`define PFM_REGS_SVH

// pin vector: [5:0] port a, [13:6] port b, [17:14] port c
`define PFM_NPIN        18
`define PFM_PA0         5'd0
`define PFM_PA2         5'd2
`define PFM_PA3         5'd3
`define PFM_PA4         5'd4
`define PFM_PA5         5'd5
`define PFM_PB5         5'd11
`define PFM_PB6         5'd12
`define PFM_PB7         5'd13
`define PFM_PC0         5'd14
`define PFM_PC1         5'd15
`define PFM_GANG_MASK   18'h3CF00

// register word offsets
`define PFM_OFS_DATA    4'h0
`define PFM_OFS_DIR     4'h1
`define PFM_OFS_PULL    4'h2
`define PFM_OFS_DRIVE   4'h3
`define PFM_OFS_SLEW    4'h4
`define PFM_OFS_GANG    4'h5
`define PFM_OFS_OPT1    4'h6
`define PFM_OFS_OPT2    4'h7
`define PFM_OFS_STAT    4'h8

// field positions
`define PFM_OPT1_DBG    0
`define PFM_OPT1_RST    1
`define PFM_OPT2_IIC    0
`define PFM_OPT2_TMR    1
`define PFM_STAT_BG     0
`define PFM_STAT_RPIN   1

// reset values
`define PFM_PIN_RST     18'h00000
`define PFM_OPT1_RSTV   1'b1
`define PFM_OPT2_RSTV   2'h0

// timing
`define PFM_BUS_HZ      50000000
`define PFM_RST_PULSE   7'd66
`define PFM_BIT_CYC     5'd16
`define PFM_BIT_SAMPLE  5'd10
`define PFM_SPEEDUP_CYC 2'd1
`define PFM_MODE_SETTLE 2'd2

`endif

// File: design/pfm_pkg.sv
package pfm_pkg;

  typedef enum logic [1:0] {
    RP_IDLE,
    RP_DRIVE,
    RP_DONE
  } pfm_rpin_state_t;

  typedef enum logic {
    MODE_RUN,
    MODE_BACKGROUND
  } pfm_mode_t;

endpackage

// File: design/pfm_sync.sv
`timescale 1ns/1ps
module pfm_sync #(
  parameter int WIDTH = 18
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          meta_reg[g] <= 1'b1;
          sync_out[g] <= 1'b1;
        end else begin
          meta_reg[g] <= async_in[g];
          sync_out[g] <= meta_reg[g];
        end
      end
    end
  endgenerate
endmodule

// File: design/pfm_bit_timer.sv
`timescale 1ns/1ps
`include "pfm_regs.svh"
module pfm_bit_timer (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic dbg_clk_en,
  input  wire logic link_en,
  input  wire logic line_in,
  output logic      bit_sample,
  output logic      bit_done,
  output logic      bit_busy
);
  logic [4:0] cnt_reg;
  logic       line_d_reg;
  logic       fall;

  assign fall = line_d_reg & ~line_in;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      line_d_reg <= 1'b1;
    end else begin
      line_d_reg <= line_in;
    end
  end

  // a bit cell opens on a falling edge and lasts 16 debug clocks
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg    <= 5'h00;
      bit_busy   <= 1'b0;
      bit_sample <= 1'b0;
      bit_done   <= 1'b0;
    end else begin
      bit_sample <= 1'b0;
      bit_done   <= 1'b0;
      if (!link_en) begin
        bit_busy <= 1'b0;
        cnt_reg  <= 5'h00;
      end else if (!bit_busy) begin
        if (fall) begin
          bit_busy <= 1'b1;
          cnt_reg  <= 5'h00;
        end
      end else if (dbg_clk_en) begin
        cnt_reg <= cnt_reg + 5'h01;
        if (cnt_reg == `PFM_BIT_SAMPLE - 5'h01) begin
          bit_sample <= 1'b1;
        end
        if (cnt_reg == `PFM_BIT_CYC - 5'h01) begin
          bit_done <= 1'b1;
          bit_busy <= 1'b0;
        end
      end
    end
  end
endmodule

// File: bench/pfm_pin_mux_checker.sv
`timescale 1ns/1ps
module pfm_pin_mux_checker (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic [17:0] pin_out,
  input wire logic [17:0] pin_oe_n,
  input wire logic [17:0] pin_pullup,
  input wire logic [17:0] pin_drive_hi,
  input wire logic [17:0] pin_slew,
  input wire logic        comparator_en,
  input wire logic        comparator_connect,
  input wire logic [1:0]  adc_en,
  input wire logic [1:0]  adc_connect,
  input wire logic        dbg_clk_en,
  input wire logic        dbg_drive_low,
  input wire logic        dbg_bit_done,
  input wire logic        dbg_bit_busy,
  input wire logic        dbg_link_active
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  logic [4:0] en_cnt_reg;

  // debug clocks seen during the current bit
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) en_cnt_reg <= 5'h00;
    else if (!dbg_bit_busy) en_cnt_reg <= 5'h00;
    else if (dbg_clk_en) en_cnt_reg <= en_cnt_reg + 5'h01;
  end

  a_link_after_reset: assert property ($rose(rst_n) |-> ##[3:5] dbg_link_active)
    else $error("debug link not active after reset");
  a_pull_on_link: assert property (dbg_link_active && $past(dbg_link_active) |-> pin_pullup[4])
    else $error("debug pin pull-up off while link active");
  a_bit_length: assert property (dbg_bit_done |-> en_cnt_reg == 5'h10)
    else $error("debug bit not sixteen debug clocks");
  a_drive_low: assert property (dbg_link_active && dbg_drive_low |=> !pin_oe_n[4] && !pin_out[4])
    else $error("debug pin not pulled low");
  a_speedup_pulse: assert property (dbg_link_active && $fell(dbg_drive_low) |=> ##1 !pin_oe_n[4] && pin_out[4])
    else $error("no speedup pulse on debug pin");
  a_idle_no_drive: assert property (((pin_drive_hi | pin_slew) & pin_oe_n) == 18'h00000)
    else $error("drive or slew set on undriven pin");
  a_reset_hiz: assert property ($rose(rst_n) |-> pin_oe_n == 18'h3FFFF && (pin_pullup & 18'h3FFEF) == 18'h00000)
    else $error("pins not high impedance after reset");
  a_shared_analog: assert property (comparator_connect == comparator_en && adc_connect == adc_en)
    else $error("analog access not shared");
  a_open_drain: assert property (!pin_oe_n[5] |-> !pin_out[5])
    else $error("port a bit5 driven high");
endmodule

bind pfm_pin_mux pfm_pin_mux_checker pfm_pin_mux_checker_inst (.*);

// File: bench/pfm_pin_partner.sv
`timescale 1ns/1ps
module pfm_pin_partner (
  input  wire logic        mclk,
  input  wire logic [17:0] pin_out,
  input  wire logic [17:0] pin_oe_n,
  input  wire logic [17:0] pin_pullup,
  input  wire logic [17:0] ext_drive,
  input  wire logic [17:0] ext_level,
  input  wire logic        host_low,
  input  wire logic        host_go,
  input  wire logic        dbg_clk_en,
  output logic      [17:0] pin_in
);
  logic [17:0] float_reg = 18'h2AAAA;
  logic [4:0]  bit_reg = 5'h00;
  logic        pull_dn;
  logic        push_hi;

  // host bit: low for four debug clocks, sixteen in all
  always @(posedge mclk) begin
    float_reg <= ~float_reg;
    if (bit_reg == 5'h00 && host_go) bit_reg <= 5'h10;
    else if (bit_reg != 5'h00 && dbg_clk_en) bit_reg <= bit_reg - 5'h01;
  end

  assign pull_dn = host_low || bit_reg > 5'h0C;
  assign push_hi = bit_reg == 5'h0C;

  // undriven floating pins toggle, never hold a value
  always_comb begin
    for (int i = 0; i < 18; i++) begin
      if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
      else if (i == 4 && (pull_dn || push_hi)) pin_in[i] = push_hi;
      else if (ext_drive[i]) pin_in[i] = ext_level[i];
      else if (pin_pullup[i]) pin_in[i] = 1'b1;
      else pin_in[i] = float_reg[i];
    end
  end
endmodule

// File: bench/pin_function_mux_mode_select_tb_top.sv
`timescale 1ns/1ps
`include "pfm_regs.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module pin_function_mux_mode_select_tb_top;
  localparam logic [17:0] M = 18'h3FFCF;
  logic        mclk, rst_n, por_n, reset_was_por, reset_was_forced, avs_read, avs_write;
  logic        avs_waitrequest, iic_en, iic_scl_out, iic_scl_oe, iic_sda_out, iic_sda_oe;
  logic        iic_scl_in, iic_sda_in, comparator_output_en, comparator_output;
  logic        comparator_en, comparator_connect, dbg_clk_en, dbg_drive_low, dbg_rx;
  logic        dbg_bit_sample, dbg_bit_done, dbg_bit_busy, dbg_link_active;
  logic        active_background, ext_reset_req, host_low, host_go;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, seed, q, r1, r2, r3;
  logic [17:0] pin_in, pin_out, pin_oe_n, pin_pullup, pin_drive_hi, pin_slew;
  logic [17:0] periph_en, periph_out, periph_oe, periph_in, ext_drive, ext_level;
  logic [17:0] dir, pd, po, inm, alt;
  logic [1:0]  timer1_en, timer1_out, timer1_oe, timer1_in, adc_en, adc_connect;
  int          fails, n_checks, cyc, n, w;

  pfm_pin_mux pfm_pin_mux_inst (.*);
  pfm_pin_partner pfm_pin_partner_inst (.*);

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic tally_and_finish;
    if (fails == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    dbg_clk_en <= cyc[0];
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  function automatic logic [17:0] exp_read(input logic [17:0] d, dt, p, pv, ex);
    return ((d & dt) | (~d & ((p & pv) | (~p & ex)))) & M;
  endfunction

  task automatic rnd(output logic [31:0] r);
    seed = xs(seed);
    r = seed;
  endtask

  task automatic bus(input logic wn, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wn;
    avs_read <= !wn;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK("readdata", e, q)
  endtask

  task automatic do_reset(input logic p);
    rst_n <= 1'b0;
    por_n <= !p;
    reset_was_por <= p;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
  endtask

  initial begin
    {rst_n, por_n, reset_was_por, reset_was_forced, avs_read, avs_write} = '0;
    {avs_address, avs_writedata, periph_en, periph_out, periph_oe, ext_level} = '0;
    {iic_en, iic_scl_out, iic_scl_oe, iic_sda_out, iic_sda_oe, timer1_en, timer1_out} = '0;
    {timer1_oe, comparator_output_en, comparator_output, comparator_en, adc_en} = '0;
    {dbg_drive_low, host_low, host_go} = '0;
    avs_byteenable = 4'hF;
    ext_drive = M;
    seed = 32'h474A2343;
    do_reset(1'b1);
    repeat (6) @(posedge mclk);
    `CHK("pin_oe_n", 18'h3FFFF, pin_oe_n)
    `CHK("pin_pullup", 18'h00010, pin_pullup)
    `CHK("dbg_link_active", 1'b1, dbg_link_active)
    rdc(`PFM_OFS_DIR, 32'h0);
    rdc(`PFM_OFS_PULL, 32'h0);
    rdc(`PFM_OFS_OPT1, 32'h1);
    rdc(`PFM_OFS_OPT2, 32'h0);
    rdc(`PFM_OFS_STAT, 32'h0);
    rdc(4'h9, 32'h0);
    host_low <= 1'b1;
    do_reset(1'b0);
    repeat (6) @(posedge mclk);
    `CHK("active_background", 1'b0, active_background)
    do_reset(1'b1);
    repeat (6) @(posedge mclk);
    host_low <= 1'b0;
    `CHK("active_background", 1'b1, active_background)
    rdc(`PFM_OFS_STAT, 32'h1);
    for (int k = 0; k < 8; k++) begin
      rnd(r1);
      rnd(r2);
      rnd(r3);
      ext_level <= r1[17:0];
      periph_out <= r1[31:14];
      periph_en <= r2[17:0] & M;
      periph_oe <= r2[31:14];
      {comparator_en, adc_en} <= r3[31:29];
      dir = r3[17:0] & M;
      pd = r2[17:0] & M & r2[31:14];
      po = dir & ~(r2[17:0] & M);
      inm = M & ~pd & ~po;
      wr(`PFM_OFS_DIR, {14'h0, dir});
      wr(`PFM_OFS_DATA, {14'h0, r3[31:14]});
      wr(`PFM_OFS_PULL, {14'h0, r1[17:0] & M});
      wr(`PFM_OFS_DRIVE, {14'h0, r2[17:0]});
      wr(`PFM_OFS_SLEW, {14'h0, r1[31:14]});
      repeat (3) @(posedge mclk);
      bus(1'b0, `PFM_OFS_DATA, 32'h0);
      `CHK("port read", exp_read(dir, r3[31:14], pd, r1[31:14], r1[17:0]), q[17:0] & M)
      `CHK("pin_oe_n", M & ~(pd | po), pin_oe_n & M)
      `CHK("pin_out", (po & r3[31:14]) | (pd & r1[31:14]), pin_out & (po | pd))
      `CHK("pin_drive_hi", (po | pd) & r2[17:0], pin_drive_hi & (po | pd))
      `CHK("pin_slew", (po | pd) & r1[31:14], pin_slew & (po | pd))
      `CHK("pin_pullup", inm & r1[17:0], pin_pullup & inm)
    end
    periph_en <= M;
    periph_oe <= M;
    periph_out <= 18'h0;
    wr(`PFM_OFS_GANG, 32'h3FFFF);
    rdc(`PFM_OFS_GANG, 32'h3CF00);
    for (int a = 0; a < 5; a++) wr(4'(a), 32'h04000);
    repeat (2) @(posedge mclk);
    `CHK("gang oe", 18'h0, pin_oe_n & 18'h3CF00)
    `CHK("gang out", 18'h3CF00, pin_out & 18'h3CF00)
    `CHK("gang drive", 18'h3CF00, pin_drive_hi & 18'h3CF00)
    `CHK("gang slew", 18'h3CF00, pin_slew & 18'h3CF00)
    periph_en <= 18'h0;
    for (int a = 0; a < 6; a++) wr(4'(a), 32'h0);
    {iic_en, iic_scl_oe, iic_sda_oe} <= 3'b111;
    {timer1_en, timer1_oe, timer1_out} <= 6'b111110;
    for (int s = 0; s < 4; s++) begin
      wr(`PFM_OFS_OPT2, 32'(s));
      repeat (2) @(posedge mclk);
      alt = (s[0] ? 18'h03000 : 18'h0000C) | (s[1] ? 18'h0C000 : 18'h00801);
      `CHK("alt oe", 18'h0F80D & ~alt, pin_oe_n & 18'h0F80D)
      `CHK("timer out", s[1] ? 18'h08000 : 18'h00800, pin_out & alt & 18'h0C801)
    end
    {iic_en, timer1_en} <= 3'b000;
    host_go <= 1'b1;
    @(posedge mclk);
    host_go <= 1'b0;
    for (w = 0; w < 200 && dbg_bit_done !== 1'b1; w++) @(posedge mclk);
    `CHK("dbg_bit_done", 1'b1, dbg_bit_done)
    dbg_drive_low <= 1'b1;
    repeat (3) @(posedge mclk);
    dbg_drive_low <= 1'b0;
    repeat (40) @(posedge mclk);
    wr(`PFM_OFS_OPT1, 32'h0);
    {comparator_output_en, comparator_output} <= 2'b11;
    repeat (2) @(posedge mclk);
    `CHK("comparator pin", 3'b001, {dbg_link_active, pin_oe_n[4], pin_out[4]})
    `CHK("pullup4", 1'b0, pin_pullup[4])
    wr(`PFM_OFS_DIR, 32'h20);
    wr(`PFM_OFS_DATA, 32'h20);
    repeat (2) @(posedge mclk);
    `CHK("pa5 high", 1'b1, pin_oe_n[5])
    wr(`PFM_OFS_DATA, 32'h0);
    repeat (2) @(posedge mclk);
    `CHK("pa5 low", 2'b00, {pin_oe_n[5], pin_out[5]})
    wr(`PFM_OFS_OPT1, 32'h2);
    ext_drive[5] <= 1'b1;
    ext_level[5] <= 1'b0;
    repeat (4) @(posedge mclk);
    `CHK("reset role", 3'b111, {pin_oe_n[5], pin_pullup[5], ext_reset_req})
    ext_drive[5] <= 1'b0;
    for (int p = 0; p < 2; p++) begin
      {reset_was_forced, host_low} <= {2{!p[0]}};
      do_reset(p[0]);
      n = 0;
      repeat (80) begin
        @(posedge mclk);
        if (pin_oe_n[5] === 1'b0) n++;
      end
      `CHK("reset pulse", (p ? 0 : 66), n)
      `CHK("mode", !p[0], active_background)
      rdc(`PFM_OFS_OPT1, p ? 32'h1 : 32'h3);
    end
    tally_and_finish();
  end
endmodule
